/* src/gpio_port_map.svh */
// Register indices, address width, widths, reset values and codes of the GPIO port
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

// ====================================================================
// Register indices and APB byte address width
`define IDX_PIN_LEVEL 16'hf250
`define IDX_PIN_DIRECTION 16'hf251
`define IDX_DRIVE_CONFIG_LOW 16'hf252
`define IDX_DRIVE_CONFIG_HIGH 16'hf253
`define ADDR_W 18

// ====================================================================
// Widths and reset values
`define PORT_W 8
`define REG_RESET 8'h00

// ====================================================================
// Per-pin drive / termination codes, {config_high, config_low}
`define CODE_HIZ 2'b00
`define CODE_PCH 2'b01
`define CODE_NCH 2'b10
`define CODE_CMOS 2'b11
`define CODE_PULL_DOWN 2'b01
`define CODE_PULL_UP 2'b10

`endif

/* src/gpio_port_pkg.sv */
// Types shared by the GPIO port modules
package gpio_port_pkg;

  typedef enum logic [2:0]
  {
    SEL_NONE = 3'h0,
    SEL_LEVEL = 3'h1,
    SEL_DIR = 3'h2,
    SEL_CFG_LO = 3'h3,
    SEL_CFG_HI = 3'h4
  } reg_sel_t;

  typedef struct packed
  {
    logic [7:0] level;
    logic [7:0] dir;
    logic [7:0] cfg_lo;
    logic [7:0] cfg_hi;
    logic [15:0] rdata;
    logic err;
  } state_t;

  function automatic logic [17:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

/* src/port_ctrl_if.sv */
// Register values and pin signals passed between controller and pad logic
`timescale 1ns/10ps
`include "gpio_port_map.svh"
interface port_ctrl_if;
  logic [`PORT_W-1:0] level;
  logic [`PORT_W-1:0] dir;
  logic [`PORT_W-1:0] cfg_lo;
  logic [`PORT_W-1:0] cfg_hi;
  logic [`PORT_W-1:0] pin_out;
  logic [`PORT_W-1:0] pin_oe;
  logic [`PORT_W-1:0] pull_up;
  logic [`PORT_W-1:0] pull_down;

  modport ctrl
  (
    output level, dir, cfg_lo, cfg_hi,
    input pin_out, pin_oe, pull_up, pull_down
  );
  modport pad
  (
    input level, dir, cfg_lo, cfg_hi,
    output pin_out, pin_oe, pull_up, pull_down
  );
endinterface

/* src/apb_reg_decode.sv */
// APB address decode to register select
`timescale 1ns/10ps
`include "gpio_port_map.svh"
module apb_reg_decode
(
  input wire logic [31:0] paddr, // APB byte address
  output gpio_port_pkg::reg_sel_t sel // Selected register
);
  always_comb
  begin
    sel = gpio_port_pkg::SEL_NONE;
    // Upper address bits must be zero; no aliasing
    if (paddr[31:`ADDR_W] == '0)
    begin
      case (paddr[`ADDR_W-1:0])
        gpio_port_pkg::byte_addr(`IDX_PIN_LEVEL):
          sel = gpio_port_pkg::SEL_LEVEL;
        gpio_port_pkg::byte_addr(`IDX_PIN_DIRECTION):
          sel = gpio_port_pkg::SEL_DIR;
        gpio_port_pkg::byte_addr(`IDX_DRIVE_CONFIG_LOW):
          sel = gpio_port_pkg::SEL_CFG_LO;
        gpio_port_pkg::byte_addr(`IDX_DRIVE_CONFIG_HIGH):
          sel = gpio_port_pkg::SEL_CFG_HI;
        default:
          sel = gpio_port_pkg::SEL_NONE;
      endcase
    end
  end
endmodule

/* src/pin_drive.sv */
// Per-pin drive type and input termination decode
`timescale 1ns/10ps
`include "gpio_port_map.svh"
module pin_drive
(
  port_ctrl_if.pad p // Register values in, pad controls out
);
  logic [1:0] code;

  always_comb
  begin
    code = 2'b00;
    p.pin_out = '0;
    p.pin_oe = '0;
    p.pull_up = '0;
    p.pull_down = '0;
    for (int i = 0; i < `PORT_W; i++)
    begin
      code = {p.cfg_hi[i], p.cfg_lo[i]};
      if (!p.dir[i])
      begin
        case (code)
          `CODE_PCH:
          begin
            // Only the high side exists
            p.pin_out[i] = 1'b1;
            p.pin_oe[i] = p.level[i];
          end
          `CODE_NCH:
          begin
            p.pin_out[i] = 1'b0;
            p.pin_oe[i] = ~p.level[i];
          end
          `CODE_CMOS:
          begin
            p.pin_out[i] = p.level[i];
            p.pin_oe[i] = 1'b1;
          end
          default:
          begin
            p.pin_out[i] = 1'b0;
            p.pin_oe[i] = 1'b0;
          end
        endcase
      end
      else
      begin
        // Code 11 falls back to a floating input
        p.pull_down[i] = (code == `CODE_PULL_DOWN);
        p.pull_up[i] = (code == `CODE_PULL_UP);
      end
    end
  end
endmodule

/* src/gpio_port.sv */
// Eight-bit GPIO port with APB register access
`timescale 1ns/10ps
`include "gpio_port_map.svh"

module gpio_port
(
  input wire logic pclk, // APB clock, 200 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, 1 write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB write byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [`PORT_W-1:0] pin_in, // Pin levels
  output logic [`PORT_W-1:0] pin_out, // Pin drive value
  output logic [`PORT_W-1:0] pin_oe, // Pin drive enable
  output logic [`PORT_W-1:0] pull_up_en, // Pull-up enable
  output logic [`PORT_W-1:0] pull_down_en // Pull-down enable
);

  // ==================================================================
  // State and decode
  gpio_port_pkg::state_t s_r;
  gpio_port_pkg::state_t s_nxt;
  gpio_port_pkg::reg_sel_t sel;
  logic setup;
  logic access;
  logic wr_take;
  logic bad;
  logic [`PORT_W-1:0] level_view;

  port_ctrl_if pc ();

  apb_reg_decode u_decode
  (
    .paddr(paddr),
    .sel(sel)
  );

  pin_drive u_pins
  (
    .p(pc.pad)
  );

  assign pc.level = s_r.level;
  assign pc.dir = s_r.dir;
  assign pc.cfg_lo = s_r.cfg_lo;
  assign pc.cfg_hi = s_r.cfg_hi;
  assign pin_out = pc.pin_out;
  assign pin_oe = pc.pin_oe;
  assign pull_up_en = pc.pull_up;
  assign pull_down_en = pc.pull_down;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  // No wait states: the answer is decided in the setup cycle
  assign pready = 1'b1;
  assign wr_take = access & pwrite & ~s_r.err;
  assign prdata = {16'h0000, s_r.rdata};
  assign pslverr = access & s_r.err;

  // Written bits for outputs, live pin for inputs
  assign level_view = (s_r.level & ~s_r.dir) | (pin_in & s_r.dir);

  // ==================================================================
  // Access checks
  always_comb
  begin
    bad = 1'b0;
    case (sel)
      gpio_port_pkg::SEL_LEVEL,
      gpio_port_pkg::SEL_DIR:
        bad = pwrite & (pstrb[3:1] != 3'b000);
      gpio_port_pkg::SEL_CFG_LO:
        bad = pwrite & (pstrb[3:2] != 2'b00);
      gpio_port_pkg::SEL_CFG_HI:
        bad = pwrite & (pstrb[3:1] != 3'b000);
      default:
        bad = 1'b1;
    endcase
  end

  // ==================================================================
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    if (setup)
    begin
      s_nxt.err = bad;
      s_nxt.rdata = 16'h0000;
      if (!pwrite && !bad)
      begin
        case (sel)
          gpio_port_pkg::SEL_LEVEL:
            s_nxt.rdata = {8'h00, level_view};
          gpio_port_pkg::SEL_DIR:
            s_nxt.rdata = {8'h00, s_r.dir};
          gpio_port_pkg::SEL_CFG_LO:
            s_nxt.rdata = {s_r.cfg_hi, s_r.cfg_lo};
          gpio_port_pkg::SEL_CFG_HI:
            s_nxt.rdata = {8'h00, s_r.cfg_hi};
          default:
            s_nxt.rdata = 16'h0000;
        endcase
      end
    end
    if (wr_take)
    begin
      case (sel)
        gpio_port_pkg::SEL_LEVEL:
          if (pstrb[0])
            s_nxt.level = pwdata[7:0];
        gpio_port_pkg::SEL_DIR:
          if (pstrb[0])
            s_nxt.dir = pwdata[7:0];
        gpio_port_pkg::SEL_CFG_LO:
        begin
          if (pstrb[0])
            s_nxt.cfg_lo = pwdata[7:0];
          if (pstrb[1])
            s_nxt.cfg_hi = pwdata[15:8];
        end
        gpio_port_pkg::SEL_CFG_HI:
          if (pstrb[0])
            s_nxt.cfg_hi = pwdata[7:0];
        default:
          s_nxt.level = s_r.level;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r.level <= `REG_RESET;
      s_r.dir <= `REG_RESET;
      s_r.cfg_lo <= `REG_RESET;
      s_r.cfg_hi <= `REG_RESET;
      s_r.rdata <= 16'h0000;
      s_r.err <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  // ==================================================================
  // Assertions
  property p_dir_reset;
    @(posedge pclk)
    $rose(presetn) |-> (s_r.dir == 8'h00) && (pin_oe == 8'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction or drive not reset");

  property p_cmos_drive;
    @(posedge pclk) disable iff (!presetn)
    ((~s_r.dir & s_r.cfg_lo & s_r.cfg_hi & (pin_out ^ s_r.level)) == 8'h00)
      && ((~s_r.dir & s_r.cfg_lo & s_r.cfg_hi & ~pin_oe) == 8'h00);
  endproperty
  a_cmos_drive: assert property (p_cmos_drive)
    else $error("CMOS pin not driving level");

  property p_read_out;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel == gpio_port_pkg::SEL_LEVEL |=>
      ((prdata[7:0] ^ $past(s_r.level)) & ~$past(s_r.dir)) == 8'h00;
  endproperty
  a_read_out: assert property (p_read_out)
    else $error("output pin readback wrong");

  property p_read_in;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel == gpio_port_pkg::SEL_LEVEL |=>
      ((prdata[7:0] ^ $past(pin_in)) & $past(s_r.dir)) == 8'h00;
  endproperty
  a_read_in: assert property (p_read_in)
    else $error("input pin level read wrong");

  property p_nch;
    @(posedge pclk) disable iff (!presetn)
    ((~s_r.dir & ~s_r.cfg_lo & s_r.cfg_hi) & (pin_oe ^ ~s_r.level)) == 8'h00;
  endproperty
  a_nch: assert property (p_nch)
    else $error("N open drain enable wrong");

  property p_pch;
    @(posedge pclk) disable iff (!presetn)
    ((~s_r.dir & s_r.cfg_lo & ~s_r.cfg_hi)
      & ((pin_oe ^ s_r.level) | ~pin_out)) == 8'h00;
  endproperty
  a_pch: assert property (p_pch)
    else $error("P open drain drive wrong");

  property p_pull;
    @(posedge pclk) disable iff (!presetn)
    pull_up_en == (s_r.dir & s_r.cfg_hi & ~s_r.cfg_lo)
      && pull_down_en == (s_r.dir & s_r.cfg_lo & ~s_r.cfg_hi)
      && (pin_oe & s_r.dir) == 8'h00;
  endproperty
  a_pull: assert property (p_pull)
    else $error("input termination wrong");

  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && !pslverr && pstrb[0]
      && sel == gpio_port_pkg::SEL_DIR |=> s_r.dir == $past(pwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write lost");

  property p_word_write;
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && !pslverr && pstrb[1:0] == 2'b11
      && sel == gpio_port_pkg::SEL_CFG_LO |=>
      {s_r.cfg_hi, s_r.cfg_lo} == $past(pwdata[15:0]);
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("16-bit config write wrong");

  property p_hi_byte_only;
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && pstrb[1] && sel == gpio_port_pkg::SEL_CFG_HI |->
      pslverr ##1 $stable(s_r.cfg_hi);
  endproperty
  a_hi_byte_only: assert property (p_hi_byte_only)
    else $error("wide access to config high accepted");

  property p_level_write;
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && !pslverr && pstrb[0]
      && sel == gpio_port_pkg::SEL_LEVEL |=>
      s_r.level == $past(pwdata[7:0]);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("level write lost");

  property p_lo_write;
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && !pslverr && pstrb[0]
      && sel == gpio_port_pkg::SEL_CFG_LO |=>
      s_r.cfg_lo == $past(pwdata[7:0]);
  endproperty
  a_lo_write: assert property (p_lo_write)
    else $error("config low write lost");

  property p_hi_write;
    @(posedge pclk) disable iff (!presetn)
    access && pwrite && !pslverr && pstrb[0]
      && sel == gpio_port_pkg::SEL_CFG_HI |=>
      s_r.cfg_hi == $past(pwdata[7:0]);
  endproperty
  a_hi_write: assert property (p_hi_write)
    else $error("config high byte write lost");

  property p_refused;
    @(posedge pclk) disable iff (!presetn)
    access && pslverr |=> $stable(s_r.level) && $stable(s_r.dir)
      && $stable(s_r.cfg_lo) && $stable(s_r.cfg_hi);
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused access changed a register");

  property p_idle_hold;
    @(posedge pclk) disable iff (!presetn)
    !(access && pwrite) |=> $stable(s_r.level) && $stable(s_r.dir)
      && $stable(s_r.cfg_lo) && $stable(s_r.cfg_hi);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("register changed without a write");

  property p_hiz_out;
    @(posedge pclk) disable iff (!presetn)
    (~s_r.dir & ~s_r.cfg_lo & ~s_r.cfg_hi & pin_oe) == 8'h00;
  endproperty
  a_hiz_out: assert property (p_hiz_out)
    else $error("high-impedance output driven");

  property p_nch_low;
    @(posedge pclk) disable iff (!presetn)
    (~s_r.dir & ~s_r.cfg_lo & s_r.cfg_hi & pin_oe & pin_out) == 8'h00;
  endproperty
  a_nch_low: assert property (p_nch_low)
    else $error("N open drain drove high");

  property p_read_dir;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel == gpio_port_pkg::SEL_DIR |=>
      prdata == {24'h000000, $past(s_r.dir)};
  endproperty
  a_read_dir: assert property (p_read_dir)
    else $error("direction read wrong");

  property p_read_word;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel == gpio_port_pkg::SEL_CFG_LO |=>
      prdata == {16'h0000, $past(s_r.cfg_hi), $past(s_r.cfg_lo)};
  endproperty
  a_read_word: assert property (p_read_word)
    else $error("config word read wrong");

  property p_read_hi;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel == gpio_port_pkg::SEL_CFG_HI |=>
      prdata == {24'h000000, $past(s_r.cfg_hi)};
  endproperty
  a_read_hi: assert property (p_read_hi)
    else $error("config high read wrong");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    setup && sel == gpio_port_pkg::SEL_NONE |=>
      s_r.err && prdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_reset_all;
    @(posedge pclk)
    $rose(presetn) |-> s_r.level == 8'h00 && s_r.cfg_lo == 8'h00
      && s_r.cfg_hi == 8'h00 && prdata == 32'h00000000 && !pslverr;
  endproperty
  a_reset_all: assert property (p_reset_all)
    else $error("registers not reset");

  property p_rdata_hold;
    @(posedge pclk) disable iff (!presetn)
    !setup |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data did not stand");

  c_cmos: cover property (@(posedge pclk) disable iff (!presetn)
    pin_oe[0] && s_r.cfg_lo[0] && s_r.cfg_hi[0] && !s_r.dir[0]);
  c_pull_up: cover property (@(posedge pclk) disable iff (!presetn)
    pull_up_en != 8'h00);
  c_word: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && pstrb[1] && sel == gpio_port_pkg::SEL_CFG_LO);
  c_err: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);

endmodule

/* test/board_pins.sv */
// Board-side model of the eight port pins
`timescale 1ns/10ps
module board_pins
(
  input wire logic pclk, // Clock for the floating pattern
  input wire logic [7:0] pin_out, // Device drive value
  input wire logic [7:0] pin_oe, // Device drive enable
  input wire logic [7:0] pull_up_en, // Device pull-up
  input wire logic [7:0] pull_down_en, // Device pull-down
  input wire logic [7:0] ext_en, // Board drives the line
  input wire logic [7:0] ext_val, // Board drive value
  output logic [7:0] pin_in // Resolved pin levels
);
  logic [7:0] flt_r = 8'h55;

  // ====================================================================
  // Line resolution
  // Undriven lines toggle every cycle so a stale level never passes
  always @(posedge pclk) flt_r <= ~flt_r;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pull_up_en[i])
        pin_in[i] = 1'b1;
      else if (pull_down_en[i])
        pin_in[i] = 1'b0;
      else
        pin_in[i] = flt_r[i];
    end
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the eight-bit GPIO port
`timescale 1ns/10ps
`include "gpio_port_map.svh"
module tb_top;
  localparam logic [31:0] A_LVL = {14'h0, `IDX_PIN_LEVEL, 2'b00};
  localparam logic [31:0] A_DIR = {14'h0, `IDX_PIN_DIRECTION, 2'b00};
  localparam logic [31:0] A_CLO = {14'h0, `IDX_DRIVE_CONFIG_LOW, 2'b00};
  localparam logic [31:0] A_CHI = {14'h0, `IDX_DRIVE_CONFIG_HIGH, 2'b00};
  localparam logic [31:0] ALL_REGS [4] = '{A_LVL, A_DIR, A_CLO, A_CHI};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
  logic [7:0] ext_en, ext_val;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 pclk = ~pclk;

  gpio_port dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en)
  );

  board_pins board
  (
    .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );

  // ====================================================================
  // Checking helpers
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
        exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      results();
    end
  end

  // One APB transfer; read data compared only on reads
  task automatic xfer(input logic w, input logic [31:0] a, d,
    input logic [3:0] s, input logic e_err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench cycle limit ends a wait for ready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, e_err}, "slave error");
    if (!w)
      chk(prdata, d, "read data");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected pads worked out per pin from direction and drive code
  task automatic pads(input logic [7:0] lv, dr, lo, hi);
    logic [7:0] oe, out, up, dn;
    oe = 8'h00;
    out = 8'h00;
    up = 8'h00;
    dn = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      case ({dr[i], hi[i], lo[i]})
        3'b001: {oe[i], out[i]} = {lv[i], lv[i]};
        3'b010: oe[i] = ~lv[i];
        3'b011: {oe[i], out[i]} = {1'b1, lv[i]};
        3'b101: dn[i] = 1'b1;
        3'b110: up[i] = 1'b1;
        default: oe[i] = 1'b0;
      endcase
    end
    @(negedge pclk);
    chk({24'h0, pin_oe}, {24'h0, oe}, "drive enable");
    chk({24'h0, pin_out & pin_oe}, {24'h0, out}, "drive value");
    chk({16'h0, pull_up_en, pull_down_en}, {16'h0, up, dn}, "pulls");
  endtask

  // ====================================================================
  // Test sequence
  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, pstrb} = 68'h0;
    {ext_en, ext_val} = 16'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ALL_REGS[i])
      xfer(1'b0, ALL_REGS[i], 32'h0, 4'h0, 1'b0);
    pads(8'h00, 8'h00, 8'h00, 8'h00);
    $display("test reset done");
    xfer(1'b1, A_CHI, 32'hcc, 4'h1, 1'b0);
    xfer(1'b1, A_CLO, 32'haa, 4'h1, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'b1, A_LVL, k ? 32'h5a : 32'ha5, 4'h1, 1'b0);
      pads(k ? 8'h5a : 8'ha5, 8'h00, 8'haa, 8'hcc);
      xfer(1'b0, A_LVL, k ? 32'h5a : 32'ha5, 4'h0, 1'b0);
    end
    $display("test output drive done");
    xfer(1'b1, A_DIR, 32'hff, 4'h1, 1'b0);
    pads(8'h5a, 8'hff, 8'haa, 8'hcc);
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    xfer(1'b0, A_LVL, 32'h3c, 4'h0, 1'b0);
    // Lines without board drive settle on the pulls
    ext_en <= 8'h99;
    ext_val <= 8'h81;
    xfer(1'b0, A_LVL, 32'hc5, 4'h0, 1'b0);
    xfer(1'b1, A_DIR, 32'h0f, 4'h1, 1'b0);
    // Board fights released outputs; readback must ignore it
    ext_en <= 8'hf9;
    ext_val <= 8'ha8;
    xfer(1'b0, A_LVL, 32'h5c, 4'h0, 1'b0);
    // Inputs without a pull are held by the board from here on
    ext_en <= 8'h09;
    ext_val <= 8'h08;
    $display("test input mode done");
    xfer(1'b1, A_CLO, 32'h5a3c, 4'h3, 1'b0);
    xfer(1'b0, A_CHI, 32'h5a, 4'h0, 1'b0);
    xfer(1'b0, A_CLO, 32'h5a3c, 4'h0, 1'b0);
    xfer(1'b1, A_CHI, 32'h1234, 4'h3, 1'b1);
    xfer(1'b0, A_CHI, 32'h5a, 4'h0, 1'b0);
    xfer(1'b1, A_LVL, 32'hffff, 4'h3, 1'b1);
    xfer(1'b0, A_LVL, 32'h5a, 4'h0, 1'b0);
    xfer(1'b0, A_CHI + 32'h4, 32'h0, 4'h0, 1'b1);
    $display("test access size done");
    results();
  end
endmodule
